/* File: verilog/darr_pkg.sv */
// constants for the activity reload router: register map, field layout, detector sizes
// assumes an axi4-lite master with 32-bit data and a 100 MHz clock
package darr_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_ACT_A = 8'h54;
  localparam logic [7:0] ADDR_ACT_B = 8'h58;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h64;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h68;
  localparam logic [31:0] ACT_A_RESET = 32'h0000_0000;
  localparam logic [31:0] ACT_B_RESET = 32'h0000_0000;
  // writable bits of the second register; 31:26, 7 and 3 read as zero
  localparam logic [31:0] ACT_B_WMASK = 32'h03FF_FF77;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ************************************************************
  // field layout
  // ************************************************************
  localparam int NUM_MON = 14;
  localparam int A_BURST_LO = 14;
  localparam int A_SEL_MON1 = 28;
  localparam int A_SEL_MON2 = 29;
  localparam int A_SEL_MON3 = 30;
  localparam int A_SEL_MON5 = 31;
  localparam int B_PM_CMD = 25;
  localparam int B_VIDEO = 24;
  localparam int B_PCT_LO = 16;
  localparam int B_THR_LO = 8;
  localparam int B_IRQ_STBY = 6;
  localparam int B_RTC_BURST = 5;
  localparam int B_PME_BURST = 4;
  localparam int B_KBM_STBY = 2;
  localparam int B_IRQ_BURST = 1;
  localparam int B_TICK_BURST = 0;
  localparam int VIDEO_MON = 11;
  // ************************************************************
  // interrupt status bits
  // ************************************************************
  localparam int NUM_EVT = 5;
  localparam int EVT_STBY = 0;
  localparam int EVT_FAST = 1;
  localparam int EVT_SLOW = 2;
  localparam int EVT_BREAK = 3;
  localparam int EVT_SMI = 4;
  // ************************************************************
  // detector sizing: 256-clock slice, 256-slice window
  // ************************************************************
  localparam int SLICE_BITS = 8;
  localparam logic [7:0] SLICE_LAST = 8'hFF;
  localparam logic [7:0] WINDOW_LAST = 8'hFF;
endpackage

/* File: verilog/darr_router.sv */
// activity reload router: two enable registers steer activity sources onto timer reloads
// assumes pins and interrupt lines are asynchronous; timers live outside and take pulses
//
// What this block does
// - bits 31:28 choose fast(1) or slow(0) burst reload for monitors 5,3,2,1
// - bits 27:14 let monitor reloads hit burst timer or stop-break
// - bits 13:0 let monitor reloads hit the global standby timer
// - bit 25 with smi enabled: command port read raises smi
// - bit 24 lets the video detector make monitor 11 reload events
// - slice of 256 clocks is busy when data phases exceed bits 15:8
// - window of 256 slices: video event once busy count reaches bits 23:16
// - bit 6: unmasked irq, nmi or init reloads global standby timer
// - bit 5: unmasked rtc line gives fast burst reload or stop-break
// - bit 4: smi, general input, power button or lid give fast burst/break
// - bit 2: keyboard or mouse line reloads global standby timer
// - bit 1: unmasked irq, nmi or init give burst or stop-break
// - bit 0: unmasked system tick gives burst or stop-break
`timescale 1ns/1ps
`default_nettype none
module darr_router (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [13:0] monitor_reload,
  input wire logic irq_activity,
  input wire logic system_tick_line,
  input wire logic rtc_interrupt_line,
  input wire logic keyboard_interrupt_line,
  input wire logic mouse_interrupt_line,
  input wire logic general_input_one_n,
  input wire logic power_button_input_n,
  input wire logic cover_switch_input,
  input wire logic smi_in_n,
  input wire logic smi_enabled,
  input wire logic pm_command_port_read,
  input wire logic pci_data_phase,
  output logic standby_reload,
  output logic fast_burst_reload,
  output logic slow_burst_reload,
  output logic stop_break,
  output logic system_management_interrupt,
  output logic irq
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync_prev;
  logic [NSYNC-1:0] rise;
  // active-low pins inverted so every bit is active high
  assign pin_raw = {~smi_in_n, cover_switch_input, ~power_button_input_n, ~general_input_one_n,
                    mouse_interrupt_line, keyboard_interrupt_line, rtc_interrupt_line,
                    system_tick_line, irq_activity};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync_prev <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end
  // events fire on assertion, not while held
  assign rise = sync2 & ~sync_prev;

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] act_a;
  logic [31:0] act_b;
  logic [4:0] irq_status;
  logic [4:0] irq_enable;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [4:0] evt;
  logic [4:0] clr;
  logic [31:0] wmask;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_comb begin
    wmask = '0;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= darr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == darr_pkg::ADDR_ACT_A || aw_addr == darr_pkg::ADDR_ACT_B ||
                        aw_addr == darr_pkg::ADDR_IRQ_ENABLE || aw_addr == darr_pkg::ADDR_IRQ_CLEAR)
                       ? darr_pkg::RESP_OKAY : darr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_a <= darr_pkg::ACT_A_RESET;
      act_b <= darr_pkg::ACT_B_RESET;
      irq_enable <= '0;
    end else if (do_write) begin
      if (aw_addr == darr_pkg::ADDR_ACT_A) begin
        act_a <= (act_a & ~wmask) | (w_data & wmask);
      end
      // reserved bits and bit 3 are kept at zero whatever is written
      if (aw_addr == darr_pkg::ADDR_ACT_B) begin
        act_b <= ((act_b & ~wmask) | (w_data & wmask)) & darr_pkg::ACT_B_WMASK;
      end
      if (aw_addr == darr_pkg::ADDR_IRQ_ENABLE && w_strb[0]) begin
        irq_enable <= w_data[4:0];
      end
    end
  end

  assign clr = (do_write && aw_addr == darr_pkg::ADDR_IRQ_CLEAR && w_strb[0]) ? w_data[4:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~clr) | evt;
      irq <= |(((irq_status & ~clr) | evt) & irq_enable);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= darr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= darr_pkg::RESP_OKAY;
        unique case (s_axi_araddr[7:0])
          darr_pkg::ADDR_ACT_A: s_axi_rdata <= act_a;
          darr_pkg::ADDR_ACT_B: s_axi_rdata <= act_b;
          darr_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {27'h000_0000, irq_status};
          darr_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= {27'h000_0000, irq_enable};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= darr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // video detector
  // ************************************************************
  logic phase_s1;
  logic phase_s2;
  logic [7:0] slice_cnt;
  logic [8:0] phase_cnt;
  logic [7:0] window_cnt;
  logic [8:0] busy_cnt;
  logic slice_busy;
  logic video_event;
  logic video_fired;
  logic video_on;

  assign video_on = act_b[darr_pkg::B_VIDEO];
  // closing cycle's phase added here, so a full slice scores 256
  assign slice_busy = phase_cnt + {8'h00, phase_s2} > {1'b0, act_b[darr_pkg::B_THR_LO +: 8]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_s1 <= 1'b0;
      phase_s2 <= 1'b0;
    end else begin
      phase_s1 <= pci_data_phase;
      phase_s2 <= phase_s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !video_on) begin
      slice_cnt <= '0;
      phase_cnt <= '0;
      window_cnt <= '0;
      busy_cnt <= '0;
      video_fired <= 1'b0;
      video_event <= 1'b0;
    end else begin
      video_event <= 1'b0;
      slice_cnt <= slice_cnt + 8'h01;
      if (slice_cnt == darr_pkg::SLICE_LAST) begin
        phase_cnt <= '0;
        window_cnt <= window_cnt + 8'h01;
        // one event per window, on reaching the percentage; the closing slice still counts
        if (slice_busy && !video_fired && busy_cnt + 9'h001 >= {1'b0, act_b[darr_pkg::B_PCT_LO +: 8]}) begin
          video_event <= 1'b1;
          video_fired <= 1'b1;
        end
        // window end clears the tally and rearms, overriding the set above
        if (window_cnt == darr_pkg::WINDOW_LAST) begin
          busy_cnt <= '0;
          video_fired <= 1'b0;
        end else if (slice_busy) begin
          busy_cnt <= busy_cnt + 9'h001;
        end
      end else if (phase_s2 && !phase_cnt[8]) begin
        phase_cnt <= phase_cnt + 9'h001;
      end
    end
  end

  // ************************************************************
  // event routing
  // ************************************************************
  logic [13:0] mon_evt;
  logic [13:0] mon_slow_sel;
  logic irq_any;
  logic pme_any;
  logic next_smi;

  always_comb begin
    mon_evt = monitor_reload;
    mon_evt[darr_pkg::VIDEO_MON] = monitor_reload[darr_pkg::VIDEO_MON] | video_event;
    // a clear select bit sends monitors 1, 2, 3 and 5 to the slow timer
    mon_slow_sel = '0;
    mon_slow_sel[1] = ~act_a[darr_pkg::A_SEL_MON1];
    mon_slow_sel[2] = ~act_a[darr_pkg::A_SEL_MON2];
    mon_slow_sel[3] = ~act_a[darr_pkg::A_SEL_MON3];
    mon_slow_sel[5] = ~act_a[darr_pkg::A_SEL_MON5];
  end

  assign irq_any = rise[0];
  assign pme_any = |rise[8:5];
  assign next_smi = act_b[darr_pkg::B_PM_CMD] && smi_enabled && pm_command_port_read;

  always_comb begin
    evt = '0;
    evt[darr_pkg::EVT_STBY] = |(mon_evt & act_a[13:0])
      | (act_b[darr_pkg::B_IRQ_STBY] & irq_any)
      | (act_b[darr_pkg::B_KBM_STBY] & (rise[3] | rise[4]));
    // monitors without a select bit, and the irq sources, take the fast timer
    evt[darr_pkg::EVT_FAST] = |(mon_evt & act_a[darr_pkg::A_BURST_LO +: 14] & ~mon_slow_sel)
      | (act_b[darr_pkg::B_RTC_BURST] & rise[2])
      | (act_b[darr_pkg::B_PME_BURST] & pme_any)
      | (act_b[darr_pkg::B_IRQ_BURST] & irq_any)
      | (act_b[darr_pkg::B_TICK_BURST] & rise[1]);
    evt[darr_pkg::EVT_SLOW] = |(mon_evt & act_a[darr_pkg::A_BURST_LO +: 14] & mon_slow_sel);
    // the same burst events double as stop-break requests
    evt[darr_pkg::EVT_BREAK] = evt[darr_pkg::EVT_FAST] | evt[darr_pkg::EVT_SLOW];
    evt[darr_pkg::EVT_SMI] = next_smi;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_reload <= 1'b0;
      fast_burst_reload <= 1'b0;
      slow_burst_reload <= 1'b0;
      stop_break <= 1'b0;
      system_management_interrupt <= 1'b0;
    end else begin
      standby_reload <= evt[darr_pkg::EVT_STBY];
      fast_burst_reload <= evt[darr_pkg::EVT_FAST];
      slow_burst_reload <= evt[darr_pkg::EVT_SLOW];
      stop_break <= evt[darr_pkg::EVT_BREAK];
      system_management_interrupt <= next_smi;
    end
  end
endmodule // darr_router
`default_nettype wire

/* File: verification/darr_router_props.sv */
// checker for the activity reload router ports
// assumes one clock domain and a bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module darr_router_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [13:0] monitor_reload,
  input wire logic smi_enabled,
  input wire logic pm_command_port_read,
  input wire logic standby_reload,
  input wire logic fast_burst_reload,
  input wire logic slow_burst_reload,
  input wire logic stop_break,
  input wire logic system_management_interrupt
);
  // ********************
  // properties
  // ********************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_answer; !s_axi_arready && s_axi_rvalid; endsequence
  sequence s_wr_taken; s_axi_awready && s_axi_wready; endsequence
  property p_rst; $rose(aresetn) |-> !(standby_reload || fast_burst_reload || stop_break); endproperty
  a_rst: assert property (p_rst) else $error("output after reset");
  property p_smi; system_management_interrupt |-> $past(pm_command_port_read && smi_enabled); endproperty
  a_smi: assert property (p_smi) else $error("smi cause");
  property p_smi_end; system_management_interrupt && !pm_command_port_read |=> !system_management_interrupt; endproperty
  a_smi_end: assert property (p_smi_end) else $error("smi too long");
  property p_slow; slow_burst_reload |-> $past(|{monitor_reload[5], monitor_reload[3:1]}); endproperty
  a_slow: assert property (p_slow) else $error("slow cause");
  property p_break; fast_burst_reload || slow_burst_reload |-> stop_break; endproperty
  a_break: assert property (p_break) else $error("burst without break");
  property p_rd; s_axi_arready |=> s_rd_answer; endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_wr; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
endmodule // darr_router_props
`default_nettype wire

/* File: verification/darr_src_model.sv */
// activity source model: interrupt, button and switch lines
// assumes one fire pulse at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module darr_src_model (
  input wire logic aclk,
  input wire logic [8:0] fire,
  output wire logic [8:0] lines
);
  // ********************
  // pin behaviour
  // ********************
  // gpi, power button and smi lines rest high
  localparam logic [8:0] IDLE = 9'h0E0;
  logic [8:0] act = 9'h000;
  int cnt = 0;
  always @(posedge aclk) begin
    if (|fire) begin
      act <= fire;
      cnt <= 4;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // off the edge, as an unrelated source would move
  assign #3 lines = (cnt > 0) ? (IDLE ^ act) : IDLE;
endmodule // darr_src_model
`default_nettype wire

/* File: verification/darr_router_tb_top.sv */
// bench top: register tasks, activity scenarios, verdict
// assumes package, design, source model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module darr_router_tb_top;
  // ********************
  // stimulus and tasks
  // ********************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [13:0] monitor_reload = 14'h0000;
  logic smi_enabled = 1'b1, pm_command_port_read = 1'b0, pci_data_phase = 1'b0, clr = 1'b0;
  logic standby_reload, fast_burst_reload, slow_burst_reload, stop_break, system_management_interrupt;
  logic [8:0] fire = 9'h000;
  wire logic [8:0] lines;
  logic [4:0] seen = 5'h00;
  int num_errors = 0, total_checks = 0;
  darr_router darr_router_inst (.*, .irq_activity(lines[0]), .system_tick_line(lines[1]),
    .rtc_interrupt_line(lines[2]), .keyboard_interrupt_line(lines[3]), .mouse_interrupt_line(lines[4]),
    .general_input_one_n(lines[5]), .power_button_input_n(lines[6]), .smi_in_n(lines[7]),
    .cover_switch_input(lines[8]));
  darr_src_model darr_src_model_inst (.aclk(aclk), .fire(fire), .lines(lines));
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    seen <= clr ? 5'h00 : seen | {system_management_interrupt, stop_break, slow_burst_reload,
      fast_burst_reload, standby_reload};
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input int dly = 0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (dly == 0);
    do begin
      @(posedge aclk);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end while (!(aw && w));
    // late bready lets the held response be watched
    if (dly > 0) begin
      repeat (dly) @(posedge aclk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input int dly = 0);
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dly == 0);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (dly > 0) begin
      repeat (dly) @(posedge aclk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_rresp});
  endtask
  // one activity event; 15 means no monitor or no pin
  task automatic run(input logic [31:0] a, input logic [31:0] b, input int m, input int p,
    input logic [4:0] e, input logic c = 1'b0, input logic v = 1'b0, input int n = 8);
    wr(darr_pkg::ADDR_ACT_A, a, darr_pkg::RESP_OKAY);
    wr(darr_pkg::ADDR_ACT_B, b, darr_pkg::RESP_OKAY);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    monitor_reload <= (m < 14) ? 14'h0001 << m : 14'h0000;
    fire <= (p < 9) ? 9'h001 << p : 9'h000;
    pm_command_port_read <= c;
    pci_data_phase <= v;
    @(posedge aclk);
    monitor_reload <= 14'h0000;
    fire <= 9'h000;
    pm_command_port_read <= 1'b0;
    repeat (n) @(posedge aclk);
    pci_data_phase <= 1'b0;
    chk("events", {27'h000_0000, e}, {27'h000_0000, seen});
  endtask
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300_000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(darr_pkg::ADDR_ACT_A, 32'h0000_0000, darr_pkg::RESP_OKAY);
    rd(darr_pkg::ADDR_ACT_B, 32'h0000_0000, darr_pkg::RESP_OKAY);
    wr(darr_pkg::ADDR_ACT_A, 32'hFFFF_FFFF, darr_pkg::RESP_OKAY);
    rd(darr_pkg::ADDR_ACT_A, 32'hFFFF_FFFF, darr_pkg::RESP_OKAY);
    wr(darr_pkg::ADDR_ACT_B, 32'hFFFF_FFF7, darr_pkg::RESP_OKAY);
    rd(darr_pkg::ADDR_ACT_B, 32'h03FF_FF77, darr_pkg::RESP_OKAY);
    wr(8'h70, 32'h0000_0001, darr_pkg::RESP_SLVERR);
    rd(8'h70, 32'h0000_0000, darr_pkg::RESP_SLVERR);
    run(32'h0000_8000, 32'h0000_0000, 1, 15, 5'h0C);
    run(32'h1000_8000, 32'h0000_0000, 1, 15, 5'h0A);
    run(32'h8008_0000, 32'h0000_0000, 5, 15, 5'h0A);
    run(32'h0000_0001, 32'h0000_0000, 0, 15, 5'h01);
    run(32'h0BFF_EFFF, 32'h0000_0000, 12, 15, 5'h00);
    run(32'h0000_0000, 32'h0000_0040, 15, 0, 5'h01);
    run(32'h0000_0000, 32'h0000_0002, 15, 0, 5'h0A);
    run(32'h0000_0000, 32'h0000_0035, 15, 0, 5'h00);
    run(32'h0000_0000, 32'h0000_0020, 15, 2, 5'h0A);
    for (int i = 5; i < 9; i++) begin
      run(32'h0000_0000, 32'h0000_0010, 15, i, 5'h0A);
    end
    run(32'h0000_0000, 32'h0000_0004, 15, 3, 5'h01);
    run(32'h0000_0000, 32'h0000_0004, 15, 4, 5'h01);
    run(32'h0000_0000, 32'h0000_0001, 15, 1, 5'h0A);
    run(32'h0000_0000, 32'h0000_0076, 15, 1, 5'h00);
    run(32'h0000_0000, 32'h0200_0000, 15, 15, 5'h10, 1'b1);
    run(32'h0000_0000, 32'h0000_0000, 15, 15, 5'h00, 1'b1);
    smi_enabled <= 1'b0;
    run(32'h0000_0000, 32'h0200_0000, 15, 15, 5'h00, 1'b1);
    smi_enabled <= 1'b1;
    run(32'h0000_0800, 32'h0101_FF00, 15, 15, 5'h01, 1'b0, 1'b1, 800);
    run(32'h0000_0800, 32'h0001_FF00, 15, 15, 5'h00, 1'b0, 1'b1, 800);
    rd(darr_pkg::ADDR_IRQ_STATUS, 32'h0000_001F, darr_pkg::RESP_OKAY, 3);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wr(darr_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001, darr_pkg::RESP_OKAY, 3);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(darr_pkg::ADDR_IRQ_CLEAR, 32'h0000_001F, darr_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rd(darr_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, darr_pkg::RESP_OKAY);
    summarize();
  end
endmodule // darr_router_tb_top
bind darr_router darr_router_props darr_router_props_inst (.*);
`default_nettype wire
